/* File: bench/usb_attach_detach_control_test.sv */
// usb_attach_detach_control_test: self-checking bench for usbadc_top
// assumes inputs change at falling edges; clkEn stays high
`timescale 1ns/10ps
module usb_attach_detach_control_test;
   import usbadc_pkg::*;
   logic clk = 1'h0, reset = 1'h1, clkEn = 1'h1, selfPowered = 1'h0, pullupSource = 1'h0;
   logic maxPowerOverride = 1'h0, personality = 1'h0, readyToEnumerate = 1'h0;
   logic wakeRequest = 1'h0, suspendDetected = 1'h0, resumeDetected = 1'h0;
   logic epInValid = 1'h0, holdOff = 1'h0, vbusLvl = 1'h1, detLvl = 1'h0, ok, ext;
   logic [3:0] pullupPinSelect = 4'h0, vbusSensePinSelect = 4'h1, base;
   logic [3:0] detachPinSelect = 4'h2, wakePinSelect = 4'h3;
   logic [8:0] maxPowerSetting = 9'h0;
   logic [15:0] gpPinIn, pins, noise = 16'h0;
   logic [7:0] epInData = 8'h0;
   logic [7:0] expQ[$];
   wire logic [15:0] gpPinOut, gpPinOeN;
   wire logic [7:0] epOutData, descMaxPower;
   wire logic internalPullupEn, lineDriveOeN, fullSpeedMode, hostRoleEn, attached;
   wire logic audioPersonality, radioEnable, loadEnable, epInReady, epOutValid, epOutReady;
   wire logic pullOff = gpPinOeN[pullupPinSelect] | !gpPinOut[pullupPinSelect];
   int seed = 32'hcc15;
   int n_errors = 0, n_tests = 0, cycles = 0, k, acc;
   usbadc_top u_dut (.clk, .reset, .clkEn, .selfPowered, .pullupSource, .pullupPinSelect,
      .vbusSensePinSelect, .detachPinSelect, .wakePinSelect, .maxPowerOverride,
      .maxPowerSetting, .personality, .readyToEnumerate, .wakeRequest, .suspendDetected,
      .resumeDetected, .gpPinIn, .gpPinOut, .gpPinOeN, .internalPullupEn, .lineDriveOeN,
      .fullSpeedMode, .hostRoleEn, .attached, .descMaxPower, .audioPersonality,
      .radioEnable, .loadEnable, .epInValid, .epInReady, .epInData, .epOutValid,
      .epOutReady, .epOutData);
   usbadc_host_model u_host (.clk, .holdOff, .epOutReady);
   always #50 clk = ~clk;
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic waitAttach(input logic want);
      for (k = 0; k < 30 && attached !== want; k++)
         @(negedge clk);
   endtask
   // holds valid until ready or a refusal after four edges
   task automatic push(input logic [7:0] d, input logic note);
      @(negedge clk);
      epInValid = 1'h1;
      epInData = d;
      ok = 1'h0;
      for (k = 0; k < 4 && !ok; k++)
      begin
         @(posedge clk);
         ok = epInReady === 1'h1;
      end
      if (ok && note)
         expQ.push_back(d);
      @(negedge clk);
      epInValid = 1'h0;
   endtask
   // noise on idle pins, chosen levels on sensed ones
   always @(negedge clk)
      noise = 16'($random(seed));
   // levels follow at once, so no race with the scenario's own negedge
   always_comb
   begin
      pins = noise;
      pins[vbusSensePinSelect] = vbusLvl;
      pins[detachPinSelect] = detLvl;
      gpPinIn = pins;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         print_verdict();
      end
      else if (epOutValid === 1'h1 && epOutReady === 1'h1)
         check(epOutData, expQ.size() > 0 ? expQ.pop_front() : 8'hxx);
   end
   initial
   begin
      for (int i = 0; i < 3; i++)
      begin
         @(negedge clk);
         reset = 1'h1;
         base = 4'($random(seed));
         pullupPinSelect = base;
         vbusSensePinSelect = base + 4'h1;
         detachPinSelect = base + 4'h2;
         wakePinSelect = base + 4'h3;
         selfPowered = i == 2;
         pullupSource = i == 1;
         ext = i != 0;
         personality = i[0];
         maxPowerOverride = i != 0;
         maxPowerSetting = 9'($random(seed));
         readyToEnumerate = 1'h0;
         repeat (8) @(negedge clk);
         check({hostRoleEn, fullSpeedMode, descMaxPower}, 10'h132);
         reset = 1'h0;
         repeat (10) @(negedge clk);
         check({attached, internalPullupEn, pullOff}, 3'h1);
         readyToEnumerate = 1'h1;
         waitAttach(1'h1);
         check({attached, internalPullupEn, lineDriveOeN, audioPersonality},
            {1'h1, !ext, 1'h0, personality});
         check({gpPinOeN[pullupPinSelect], gpPinOut[pullupPinSelect]}, {!ext, 1'h1});
         check(descMaxPower, maxPowerOverride ? maxPowerSetting[8:1] : 8'h32);
         // far side stalls while the buffer fills to refusal
         holdOff = 1'h1;
         acc = 0;
         do
         begin
            push(8'($random(seed)), 1'h1);
            acc += int'(ok);
         end
         while (ok && acc < 40);
         check(acc >= FIFO_DEPTH && acc <= FIFO_DEPTH + 2, 1'h1);
         holdOff = 1'h0;
         for (k = 0; k < 300 && expQ.size() > 0; k++)
            @(negedge clk);
         check(16'(expQ.size()), 16'h0);
         wakeRequest = 1'h1;
         detLvl = 1'h1;
         repeat (2) @(negedge clk);
         check(attached, 1'h1);
         waitAttach(1'h0);
         repeat (2) @(negedge clk);
         check({internalPullupEn, lineDriveOeN, pullOff, gpPinOeN[wakePinSelect],
            gpPinOut[wakePinSelect]}, 5'h0d);
         // a word offered while detached must never come out
         push(8'h5a, 1'h0);
         detLvl = 1'h0;
         wakeRequest = 1'h0;
         waitAttach(1'h1);
         check({attached, gpPinOeN[wakePinSelect]}, 2'h3);
         vbusLvl = 1'h0;
         repeat (5) @(negedge clk);
         check({attached, internalPullupEn, pullOff}, 3'h1);
         vbusLvl = 1'h1;
         waitAttach(1'h1);
         suspendDetected = 1'h1;
         @(negedge clk);
         suspendDetected = 1'h0;
         repeat (4) @(negedge clk);
         check({lineDriveOeN, radioEnable, loadEnable}, {1'h1, selfPowered, selfPowered});
         resumeDetected = 1'h1;
         @(negedge clk);
         resumeDetected = 1'h0;
         repeat (4) @(negedge clk);
         check({attached, lineDriveOeN, radioEnable, loadEnable}, 4'hb);
      end
      print_verdict();
   end
endmodule

/* File: bench/usbadc_host_model.sv */
// usbadc_host_model: host side draining the endpoint stream
// assumes the bench raises holdOff to stall the drain completely
`timescale 1ns/10ps
module usbadc_host_model (
   // clocking
   input wire logic clk,
   // stream
   input wire logic holdOff,
   output logic epOutReady
);
   int seed = 32'hcc15;
   initial epOutReady = 1'h0;
   // host polls once per clock at each falling edge, with random gaps
   always @(negedge clk)
      epOutReady <= !holdOff && ($random(seed) % 4 != 0);
endmodule

/* File: bench/usbadc_top_checker.sv */
// usbadc_top_checker: port assertions for usbadc_top
// assumes pin selects and pull-up source change only in reset
`timescale 1ns/10ps
module usbadc_top_checker
   import usbadc_pkg::*;
#(
   parameter int NUM_PIN = 16,
   parameter int SEL_W = 4
) (
   // clocking
   input wire logic clk,
   input wire logic reset,
   // configuration
   input wire logic selfPowered,
   input wire logic pullupSource,
   input wire logic [SEL_W-1:0] pullupPinSelect,
   input wire logic [SEL_W-1:0] vbusSensePinSelect,
   input wire logic [SEL_W-1:0] detachPinSelect,
   input wire logic [SEL_W-1:0] wakePinSelect,
   input wire logic wakeRequest,
   // pins
   input wire logic [NUM_PIN-1:0] gpPinIn,
   input wire logic [NUM_PIN-1:0] gpPinOut,
   input wire logic [NUM_PIN-1:0] gpPinOeN,
   // line control
   input wire logic internalPullupEn,
   input wire logic lineDriveOeN,
   input wire logic fullSpeedMode,
   input wire logic hostRoleEn,
   input wire logic attached
);
   logic vb, dt, ext, pullPin, pull, wake;
   assign vb = gpPinIn[vbusSensePinSelect];
   assign dt = gpPinIn[detachPinSelect];
   assign ext = pullupSource | selfPowered;
   assign pullPin = !gpPinOeN[pullupPinSelect] & gpPinOut[pullupPinSelect];
   assign pull = internalPullupEn | pullPin;
   assign wake = !gpPinOeN[wakePinSelect] & gpPinOut[wakePinSelect];
   // pins pass a two-flop sync, so five samples cover the lag
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   chk_host_role: assert property (!hostRoleEn && fullSpeedMode)
      else $error("host role or rate wrong");
   chk_vbus_gate: assert property (!vb [*5] |-> !attached && !pull)
      else $error("pulled up without vbus");
   chk_detach_off: assert property (dt [*5] |-> !attached && !pull && lineDriveOeN)
      else $error("lines active while detached");
   chk_sync_delay: assert property ($rose(dt) && attached |=> attached [*2])
      else $error("detach acted before sync");
   chk_int_pullup: assert property (ext [*2] |-> !internalPullupEn)
      else $error("internal pull-up with pin source");
   chk_ext_drive: assert property (attached && ext |-> pullPin)
      else $error("pull-up pin not driven");
   chk_wake_drive: assert property (dt [*5] ##0 wakeRequest |=> wake)
      else $error("wake not driven");
   chk_wake_idle: assert property (wake |-> !attached)
      else $error("wake driven while attached");
   chk_reattach: assert property ($fell(dt) && vb |-> ##[2:8] attached)
      else $error("no reattach");
   cov_ext_attach: cover property (attached && ext);
   cov_wake: cover property (wake);
   cov_reattach: cover property ($fell(dt) && vb);
endmodule
bind usbadc_top usbadc_top_checker #(.NUM_PIN(NUM_PIN), .SEL_W(SEL_W)) u_chk (
   .clk, .reset, .selfPowered, .pullupSource, .pullupPinSelect, .vbusSensePinSelect,
   .detachPinSelect, .wakePinSelect, .wakeRequest, .gpPinIn, .gpPinOut, .gpPinOeN,
   .internalPullupEn, .lineDriveOeN, .fullSpeedMode, .hostRoleEn, .attached);

/* File: rtl/usbadc_fifo.sv */
// usbadc_fifo: synchronous fifo with valid/ready on both sides
// assumes one clock; drain side may stall
`timescale 1ns/10ps
module usbadc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clocking
   input wire logic clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic flush,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [AW:0] count_r;
   logic doWr;
   logic doRd;
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
      begin
         $error("usbadc_fifo: DEPTH must be a power of two, at least 2");
      end
   end
   assign inReady = (count_r != (AW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;
   assign outData = mem[rdPtr_r];
   always_ff @(posedge clk)
   begin
      if (clkEn && doWr)
      begin
         mem[wrPtr_r] <= inData;
      end
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end
      else if (clkEn)
      begin
         if (flush)
         begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
         end
         else
         begin
            if (doWr)
            begin
               wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doRd)
            begin
               rdPtr_r <= rdPtr_r + 1'b1;
            end
            if (doWr && !doRd)
            begin
               count_r <= count_r + 1'b1;
            end
            else if (doRd && !doWr)
            begin
               count_r <= count_r - 1'b1;
            end
         end
      end
   end
endmodule

/* File: rtl/usbadc_pkg.sv */
// usbadc_pkg: constants shared by the usb attach/detach control block
// assumes a 10 MHz core clock and a general-purpose pin bank of NUM_PINS
package usbadc_pkg;
   localparam int CLK_HZ = 10000000;
   localparam int NUM_PINS = 16;
   localparam int PIN_SEL_W = 4;
   localparam int FIFO_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int POWER_W = 9;
   // default maximum-power request in mA
   localparam logic [POWER_W-1:0] DEFAULT_POWER_MA = 9'h064;
   // descriptor field counts in 2 mA units
   localparam int POWER_UNIT_MA = 2;
   // full-speed bit rate
   localparam int FS_BIT_RATE = 12000000;
   // pull-up source codes
   localparam logic PULLUP_INTERNAL = 1'b0;
   localparam logic PULLUP_EXTERNAL = 1'b1;
   // endpoint personality codes
   localparam logic PERSONA_WIRELESS = 1'b0;
   localparam logic PERSONA_AUDIO = 1'b1;
   // pin select reset values
   localparam logic [PIN_SEL_W-1:0] PULLUP_PIN_RST = 4'h0;
   localparam logic [PIN_SEL_W-1:0] VBUS_PIN_RST = 4'h1;
   localparam logic [PIN_SEL_W-1:0] DETACH_PIN_RST = 4'h2;
   localparam logic [PIN_SEL_W-1:0] WAKE_PIN_RST = 4'h3;
   // attach state machine
   typedef enum logic [3:0] {
      ST_DETACHED = 4'h1,
      ST_ATTACHED = 4'h2,
      ST_SUSPENDED = 4'h4,
      ST_FORCED_OFF = 4'h8
   } usbadc_state_e;
endpackage

/* File: rtl/usbadc_sync.sv */
// usbadc_sync: two-flop synchroniser for a bank of pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/10ps
module usbadc_sync #(
   parameter int WIDTH = 16
) (
   // clocking
   input wire logic clk,
   input wire logic reset,
   input wire logic clkEn,
   // data
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_r;
   initial
   begin
      if (WIDTH < 1)
      begin
         $error("usbadc_sync: WIDTH must be positive");
      end
   end
   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         stage1_r <= '0;
         syncOut <= '0;
      end
      else if (clkEn)
      begin
         stage1_r <= asyncIn;
         syncOut <= stage1_r;
      end
   end
endmodule

/* File: rtl/usbadc_top.sv */
// usbadc_top: attach, detach, vbus gating, wake and suspend control
// for a full-speed usb peripheral port.
// assumes a serial interface engine outside handles packets; this block
// owns line enables, pull-up choice, pin mapping and power request.
// Contract
// - device acts only as full-speed peripheral, never bus host
// - two selectable endpoint personalities: wireless transport or audio class
// - internal weak D+ pull-up enabled only when ready to enumerate; in suspend it stays on if readyToEnumerate drops
// - setting picks internal or pin-driven external pull-up; default internal
// - self-powered designs drive D+ pull-up via a dedicated pin
// - no D+ pull while vbus inactive; attach only with vbus powered
// - vbus sense input selectable from any general-purpose pin
// - bus-powered default current request is 100 mA
// - maximum-power value replaceable by configuration key
// - detach input and wake output each mappable to any pin
// - detach high tri-states both data lines and drops pull-up
// - detach low reattaches, re-enables pull-up, awaits enumeration
// - active-high wake output, used only while detach asserted
// - bus-powered suspend stops radio and switches off external loads
// - device and usb 2.0 host run at full speed, 12 Mbit/s
`timescale 1ns/10ps
module usbadc_top
   import usbadc_pkg::*;
#(
   parameter int NUM_PIN = usbadc_pkg::NUM_PINS,
   parameter int SEL_W = usbadc_pkg::PIN_SEL_W,
   parameter int DATA_W = usbadc_pkg::FIFO_W,
   parameter int DEPTH = usbadc_pkg::FIFO_DEPTH
) (
   // clocking
   input wire logic clk,
   input wire logic reset,
   input wire logic clkEn,
   // configuration
   input wire logic selfPowered,
   input wire logic pullupSource,
   input wire logic [SEL_W-1:0] pullupPinSelect,
   input wire logic [SEL_W-1:0] vbusSensePinSelect,
   input wire logic [SEL_W-1:0] detachPinSelect,
   input wire logic [SEL_W-1:0] wakePinSelect,
   input wire logic maxPowerOverride,
   input wire logic [usbadc_pkg::POWER_W-1:0] maxPowerSetting,
   input wire logic personality,
   input wire logic readyToEnumerate,
   // firmware events
   input wire logic wakeRequest,
   input wire logic suspendDetected,
   input wire logic resumeDetected,
   // general-purpose pins
   input wire logic [NUM_PIN-1:0] gpPinIn,
   output logic [NUM_PIN-1:0] gpPinOut,
   output logic [NUM_PIN-1:0] gpPinOeN,
   // usb line control
   output logic internalPullupEn,
   output logic lineDriveOeN,
   output logic fullSpeedMode,
   output logic hostRoleEn,
   // status
   output logic attached,
   output logic [7:0] descMaxPower,
   output logic audioPersonality,
   output logic radioEnable,
   output logic loadEnable,
   // endpoint data stream
   input wire logic epInValid,
   output logic epInReady,
   input wire logic [DATA_W-1:0] epInData,
   output logic epOutValid,
   input wire logic epOutReady,
   output logic [DATA_W-1:0] epOutData
);
   import usbadc_pkg::*;

   usbadc_state_e state_r;
   usbadc_state_e state_nxt;
   logic [NUM_PIN-1:0] pinSync;
   logic vbusLevel;
   logic detachLevel;
   logic wake_r;
   logic [DATA_W-1:0] outData_r;
   logic outHeld_r;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [DATA_W-1:0] fifoOutData;
   logic extPullupOn;
   logic [POWER_W-1:0] powerMa;
   logic [POWER_W-1:0] powerUnits;

   initial
   begin
      if ((1 << SEL_W) < NUM_PIN)
      begin
         $error("usbadc_top: SEL_W too narrow for NUM_PIN");
      end
      if (POWER_UNIT_MA != 2)
      begin
         $error("usbadc_top: power unit must be 2 mA");
      end
   end

   usbadc_sync #(
      .WIDTH(NUM_PIN)
   ) u_sync (
      .clk(clk),
      .reset(reset),
      .clkEn(clkEn),
      .asyncIn(gpPinIn),
      .syncOut(pinSync)
   );

   assign vbusLevel = pinSync[vbusSensePinSelect];
   assign detachLevel = pinSync[detachPinSelect];

   // attach state machine; forced-off wins over every other event
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_DETACHED:
         begin
            if (detachLevel)
            begin
               state_nxt = ST_FORCED_OFF;
            end
            else if (vbusLevel && readyToEnumerate)
            begin
               state_nxt = ST_ATTACHED;
            end
         end
         ST_ATTACHED:
         begin
            if (detachLevel)
            begin
               state_nxt = ST_FORCED_OFF;
            end
            else if (!vbusLevel || !readyToEnumerate)
            begin
               state_nxt = ST_DETACHED;
            end
            else if (suspendDetected)
            begin
               state_nxt = ST_SUSPENDED;
            end
         end
         ST_SUSPENDED:
         begin
            if (detachLevel)
            begin
               state_nxt = ST_FORCED_OFF;
            end
            else if (!vbusLevel)
            begin
               state_nxt = ST_DETACHED;
            end
            else if (resumeDetected)
            begin
               state_nxt = ST_ATTACHED;
            end
         end
         ST_FORCED_OFF:
         begin
            if (!detachLevel)
            begin
               state_nxt = ST_DETACHED;
            end
         end
         default:
         begin
            state_nxt = ST_DETACHED;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_r <= ST_DETACHED;
      end
      else if (clkEn)
      begin
         state_r <= state_nxt;
      end
   end

   // wake only while detached by pin
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wake_r <= 1'b0;
      end
      else if (clkEn)
      begin
         wake_r <= wakeRequest && (state_nxt == ST_FORCED_OFF);
      end
   end

   // pull-up and line control from state
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         internalPullupEn <= 1'b0;
         extPullupOn <= 1'b0;
         lineDriveOeN <= 1'b1;
         attached <= 1'b0;
      end
      else if (clkEn)
      begin
         attached <= (state_nxt == ST_ATTACHED) || (state_nxt == ST_SUSPENDED);
         lineDriveOeN <= (state_nxt != ST_ATTACHED);
         internalPullupEn <= ((state_nxt == ST_ATTACHED) || (state_nxt == ST_SUSPENDED))
            && !selfPowered && (pullupSource == PULLUP_INTERNAL);
         extPullupOn <= ((state_nxt == ST_ATTACHED) || (state_nxt == ST_SUSPENDED))
            && (selfPowered || (pullupSource == PULLUP_EXTERNAL));
      end
   end

   // per-pin drive; unselected pins stay released
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PIN; gi++)
      begin : g_pin
         assign gpPinOut[gi] = (SEL_W'(gi) == wakePinSelect) ? wake_r : 1'b1;
         assign gpPinOeN[gi] = !(((SEL_W'(gi) == wakePinSelect) && (state_r == ST_FORCED_OFF))
            || ((SEL_W'(gi) == pullupPinSelect) && extPullupOn));
      end
   endgenerate

   assign powerMa = maxPowerOverride ? maxPowerSetting : DEFAULT_POWER_MA;
   assign powerUnits = powerMa >> 1;

   // suspend drops radio and loads when bus-powered
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         descMaxPower <= DEFAULT_POWER_MA[8:1];
         audioPersonality <= 1'b0;
         radioEnable <= 1'b0;
         loadEnable <= 1'b0;
      end
      else if (clkEn)
      begin
         descMaxPower <= powerUnits[7:0];
         audioPersonality <= (personality == PERSONA_AUDIO);
         radioEnable <= selfPowered || (state_nxt != ST_SUSPENDED);
         loadEnable <= selfPowered || (state_nxt != ST_SUSPENDED);
      end
   end

   assign hostRoleEn = 1'b0;
   assign fullSpeedMode = 1'b1;

   // endpoint buffer; cleared outside ST_ATTACHED, but a word already held in the output register can still come out
   usbadc_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset(reset),
      .clkEn(clkEn),
      .flush(state_r != ST_ATTACHED),
      .inValid(epInValid && (state_r == ST_ATTACHED)),
      .inReady(epInReady),
      .inData(epInData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // output register stage keeps data from flops
   assign fifoOutReady = !outHeld_r || epOutReady;
   assign epOutValid = outHeld_r;
   assign epOutData = outData_r;
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         outHeld_r <= 1'b0;
         outData_r <= '0;
      end
      else if (clkEn)
      begin
         if (fifoOutReady)
         begin
            outHeld_r <= fifoOutValid;
            outData_r <= fifoOutData;
         end
      end
   end
endmodule
